// *** rtl/tcm_pkg.sv ***
package tcm_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TRIGGER_POINT_MASK = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_WPTR = 8'h0C;
    localparam logic [7:0] OFF_RD_ADDR = 8'h10;
    localparam logic [7:0] OFF_RD_DATA = 8'h14;

    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DELAY_LSB = 4;
    localparam int CTRL_FILTER_LSB = 8;
    localparam int CTRL_STEP_BIT = 12;
    localparam int CTRL_METHOD_BIT = 16;
    localparam int CTRL_STOP_BIT = 30;
    localparam int CTRL_ARM_BIT = 31;

    // status field positions
    localparam int ST_HALTED_BIT = 0;
    localparam int ST_RUN_BIT = 1;
    localparam int ST_WRAP_BIT = 2;
    localparam int ST_WAIT_BIT = 3;
    localparam int ST_FULL_BIT = 4;

    // counts
    localparam int TRACE_DEPTH = 4194304;
    localparam int EVENT_POINTS = 16;
    localparam int PRE_CYCLES = 255;
    localparam int POST_CYCLES = 256;
    localparam int WINDOW_CYCLES = 512;
    localparam int DELAY_STEPS = 4;
    localparam logic [15:0] TRIGGER_POINT_MASK_RST = 16'h0000;

    typedef enum logic [2:0] {
        MODE_FILL_STOP = 3'h0,
        MODE_FILL_FULL = 3'h1,
        MODE_AROUND_TRIGGER_POINT = 3'h2,
        MODE_REP_STOP = 3'h3,
        MODE_REP_FULL = 3'h4
    } tcm_mode_e;

    typedef enum logic [1:0] {
        FILT_ALL = 2'h0,
        FILT_CAPTURE = 2'h1,
        FILT_NO_CAPTURE = 2'h2
    } tcm_filt_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT_EXT = 4'b0010,
        ST_RUN = 4'b0100,
        ST_HALT = 4'b1000
    } tcm_state_e;

    typedef struct packed {
        logic sw_method;
        logic step_rec;
        tcm_filt_e filter;
        logic [2:0] delay_sel;
        tcm_mode_e mode;
    } tcm_ctrl_s;

    localparam tcm_ctrl_s CTRL_RST = '{sw_method: 1'b0, step_rec: 1'b0, filter: FILT_ALL,
                                       delay_sel: 3'h0, mode: MODE_FILL_STOP};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } tcm_apb_req_s;

endpackage

// *** rtl/tcm_trace_ctrl.sv ***
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
// Function
// - when full and still acquiring, overwrite oldest records first, circularly
// - exactly five acquisition modes are selectable
// - trace memory holds up to 4M records, one per bus cycle
// - fill until stop keeps wrapping until the target program stops
// - fill until full halts before any stored record is overwritten
// - fill around trigger halts only tracing a set delay after a hit
// - post-trigger delay is 0, 1M, 2M, 3M or 4M cycles only
// - trigger condition is built from at most 16 event points
// - repeat modes store 255 cycles before, hit cycle, 256 after
// - repeat fill until stop captures windows until break or forced stop
// - repeat fill until full halts when memory overflows
// - consecutive trigger hits mark only the first as trigger position
// - capture filtering applies only to the three non-repeat modes
// - step execution recorded only in fill until stop, by its setting; both repeat modes record it regardless
// - trigger applies to around and repeat modes, delay to around only
// - external-trigger acquisition method is selected after reset
module tcm_trace_ctrl #(
    parameter int DEPTH = tcm_pkg::TRACE_DEPTH,
    parameter int DATA_W = 31 // bus data plus trigger mark fill one read word
) (
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // observed target bus
    input wire logic cyc_valid_in,
    input wire logic [DATA_W-1:0] cyc_data_in,
    input wire logic target_stop_in,
    input wire logic step_active_in,
    // event condition logic
    input wire logic [tcm_pkg::EVENT_POINTS-1:0] event_hit_in,
    input wire logic capture_qual_in,
    input wire logic ext_trig_in,
    // status
    output logic halted_out
);
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int CNT_W = ADDR_W + 1;
    localparam logic [ADDR_W-1:0] LAST = ADDR_W'(DEPTH - 1);
    localparam logic [ADDR_W-1:0] LAST_WIN = ADDR_W'(DEPTH - tcm_pkg::WINDOW_CYCLES);
    localparam logic [ADDR_W-1:0] PRE_SPAN = ADDR_W'(tcm_pkg::PRE_CYCLES + 1);
    localparam logic [ADDR_W-1:0] WIN_SPAN = ADDR_W'(tcm_pkg::WINDOW_CYCLES);
    localparam logic [CNT_W-1:0] QUARTER = CNT_W'(DEPTH / tcm_pkg::DELAY_STEPS);
    localparam logic [CNT_W-1:0] POST_LAST = CNT_W'(tcm_pkg::POST_CYCLES - 1);

    typedef struct packed {
        tcm_pkg::tcm_state_e st;
        tcm_pkg::tcm_ctrl_s ctrl;
        logic [tcm_pkg::EVENT_POINTS-1:0] trigger_point_mask;
        logic [ADDR_W-1:0] wptr;
        logic [ADDR_W-1:0] rd_addr;
        logic [7:0] spec;
        logic [CNT_W-1:0] post_cnt;
        logic trig_seen;
        logic in_post;
        logic trigger_point_prev;
        logic ext_prev;
        logic wrapped;
        logic full;
        logic [31:0] prdata;
    } tcm_state_s;

    tcm_state_s cur_ff;
    tcm_state_s nxt_st;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [DATA_W:0] mem_rdata;
    logic trigger_point_raw;
    logic trigger_point_hit;
    logic first_hit;
    logic is_rep;
    logic filt_ok;
    logic step_ok;
    logic [CNT_W-1:0] delay_cnt;
    logic [CNT_W-1:0] post_now;
    logic setup;
    logic wr_acc;
    logic mapped;
    logic stop_now;

    always_comb
    begin
        nxt_st = cur_ff;
        mem_we = 1'b0;
        mem_waddr = cur_ff.wptr;
        post_now = cur_ff.post_cnt;
        is_rep = (cur_ff.ctrl.mode == tcm_pkg::MODE_REP_STOP) ||
                 (cur_ff.ctrl.mode == tcm_pkg::MODE_REP_FULL);
        trigger_point_raw = |(event_hit_in & cur_ff.trigger_point_mask);
        trigger_point_hit = trigger_point_raw &&
            (is_rep || cur_ff.ctrl.mode == tcm_pkg::MODE_AROUND_TRIGGER_POINT);
        first_hit = trigger_point_hit && !cur_ff.trigger_point_prev;
        // codes above four clamp so the delay never passes the memory size
        if (cur_ff.ctrl.delay_sel > 3'h4)
        begin
            delay_cnt = CNT_W'(DEPTH);
        end
        else
        begin
            delay_cnt = CNT_W'(QUARTER * CNT_W'(cur_ff.ctrl.delay_sel));
        end
        case (cur_ff.ctrl.filter)
            tcm_pkg::FILT_CAPTURE: filt_ok = capture_qual_in;
            tcm_pkg::FILT_NO_CAPTURE: filt_ok = !capture_qual_in;
            default: filt_ok = 1'b1;
        endcase
        step_ok = !step_active_in ||
                  (cur_ff.ctrl.mode == tcm_pkg::MODE_FILL_STOP && cur_ff.ctrl.step_rec);
        setup = psel_in && !penable_in;
        wr_acc = psel_in && penable_in && pwrite_in;
        mapped = (paddr_in[31:8] == 24'h000000) && (paddr_in[7:0] <= tcm_pkg::OFF_RD_DATA) &&
                 (paddr_in[1:0] == 2'h0);
        stop_now = wr_acc && mapped && paddr_in[7:0] == tcm_pkg::OFF_CTRL &&
                   pwdata_in[tcm_pkg::CTRL_STOP_BIT];

        ////////////////////////////////////////////////////////////////////////////////
        // acquisition
        if (cyc_valid_in)
        begin
            nxt_st.trigger_point_prev = trigger_point_hit;
        end
        nxt_st.ext_prev = ext_trig_in;
        case (cur_ff.st)
            tcm_pkg::ST_IDLE:
            begin
                nxt_st.st = tcm_pkg::ST_IDLE;
            end
            tcm_pkg::ST_WAIT_EXT:
            begin
                if (ext_trig_in && !cur_ff.ext_prev)
                begin
                    nxt_st.st = tcm_pkg::ST_RUN;
                end
            end
            tcm_pkg::ST_RUN:
            begin
                if (cyc_valid_in && is_rep)
                begin
                    // filters ignored here: every cycle lands in the window
                    mem_we = 1'b1;
                    if (!cur_ff.in_post)
                    begin
                        // the pre block is a 256-slot ring; oldest sits after the hit
                        mem_waddr = cur_ff.wptr + ADDR_W'(cur_ff.spec);
                        nxt_st.spec = cur_ff.spec + 8'h01;
                        if (first_hit)
                        begin
                            nxt_st.in_post = 1'b1;
                            nxt_st.post_cnt = {CNT_W{1'b0}};
                        end
                    end
                    else
                    begin
                        mem_waddr = cur_ff.wptr + PRE_SPAN + ADDR_W'(cur_ff.post_cnt);
                        nxt_st.post_cnt = cur_ff.post_cnt + CNT_W'(1);
                        if (cur_ff.post_cnt == POST_LAST)
                        begin
                            nxt_st.in_post = 1'b0;
                            nxt_st.spec = 8'h00;
                            nxt_st.wptr = cur_ff.wptr + WIN_SPAN;
                            if (cur_ff.wptr == LAST_WIN)
                            begin
                                nxt_st.wrapped = 1'b1;
                                if (cur_ff.ctrl.mode == tcm_pkg::MODE_REP_FULL)
                                begin
                                    nxt_st.full = 1'b1;
                                    nxt_st.st = tcm_pkg::ST_HALT;
                                end
                            end
                        end
                    end
                end
                else if (cyc_valid_in)
                begin
                    if (filt_ok && step_ok)
                    begin
                        mem_we = 1'b1;
                        nxt_st.wptr = cur_ff.wptr + ADDR_W'(1);
                        if (cur_ff.wptr == LAST)
                        begin
                            nxt_st.wrapped = 1'b1;
                            if (cur_ff.ctrl.mode == tcm_pkg::MODE_FILL_FULL)
                            begin
                                nxt_st.full = 1'b1;
                                nxt_st.st = tcm_pkg::ST_HALT;
                            end
                        end
                    end
                    if (cur_ff.ctrl.mode == tcm_pkg::MODE_AROUND_TRIGGER_POINT &&
                        (cur_ff.trig_seen || first_hit))
                    begin
                        // program keeps running; only the tracing stops
                        post_now = cur_ff.trig_seen ? cur_ff.post_cnt : delay_cnt;
                        nxt_st.trig_seen = 1'b1;
                        if (post_now == {CNT_W{1'b0}})
                        begin
                            nxt_st.st = tcm_pkg::ST_HALT;
                        end
                        else
                        begin
                            nxt_st.post_cnt = post_now - CNT_W'(1);
                        end
                    end
                end
                if (target_stop_in || stop_now)
                begin
                    nxt_st.st = tcm_pkg::ST_HALT;
                end
            end
            tcm_pkg::ST_HALT:
            begin
                nxt_st.st = tcm_pkg::ST_HALT;
            end
            default:
            begin
                nxt_st.st = tcm_pkg::ST_IDLE;
            end
        endcase
        if (stop_now && cur_ff.st == tcm_pkg::ST_WAIT_EXT)
        begin
            nxt_st.st = tcm_pkg::ST_HALT;
        end

        ////////////////////////////////////////////////////////////////////////////////
        // register writes
        if (wr_acc && mapped)
        begin
            case (paddr_in[7:0])
                tcm_pkg::OFF_CTRL:
                begin
                    // modes beyond the five keep the previous selection
                    if (pwdata_in[tcm_pkg::CTRL_MODE_LSB +: 3] <= 3'h4)
                    begin
                        nxt_st.ctrl.mode = tcm_pkg::tcm_mode_e'(
                            pwdata_in[tcm_pkg::CTRL_MODE_LSB +: 3]);
                    end
                    nxt_st.ctrl.delay_sel = pwdata_in[tcm_pkg::CTRL_DELAY_LSB +: 3];
                    nxt_st.ctrl.filter = tcm_pkg::tcm_filt_e'(
                        pwdata_in[tcm_pkg::CTRL_FILTER_LSB +: 2]);
                    nxt_st.ctrl.step_rec = pwdata_in[tcm_pkg::CTRL_STEP_BIT];
                    nxt_st.ctrl.sw_method = pwdata_in[tcm_pkg::CTRL_METHOD_BIT];
                    if (pwdata_in[tcm_pkg::CTRL_ARM_BIT] && !pwdata_in[tcm_pkg::CTRL_STOP_BIT])
                    begin
                        nxt_st.st = pwdata_in[tcm_pkg::CTRL_METHOD_BIT] ?
                                    tcm_pkg::ST_RUN : tcm_pkg::ST_WAIT_EXT;
                        nxt_st.wptr = {ADDR_W{1'b0}};
                        nxt_st.spec = 8'h00;
                        nxt_st.post_cnt = {CNT_W{1'b0}};
                        nxt_st.trig_seen = 1'b0;
                        nxt_st.in_post = 1'b0;
                        nxt_st.trigger_point_prev = 1'b0;
                        nxt_st.wrapped = 1'b0;
                        nxt_st.full = 1'b0;
                    end
                end
                tcm_pkg::OFF_TRIGGER_POINT_MASK:
                    nxt_st.trigger_point_mask = pwdata_in[tcm_pkg::EVENT_POINTS-1:0];
                tcm_pkg::OFF_RD_ADDR: nxt_st.rd_addr = pwdata_in[ADDR_W-1:0];
                default: nxt_st.rd_addr = cur_ff.rd_addr;
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////////
        // read data prepared in the setup cycle, presented in the access cycle
        if (setup)
        begin
            nxt_st.prdata = 32'h00000000;
            case (paddr_in[7:0])
                tcm_pkg::OFF_CTRL:
                    nxt_st.prdata = {15'h0000, cur_ff.ctrl.sw_method, 3'h0,
                                     cur_ff.ctrl.step_rec, 2'h0, cur_ff.ctrl.filter, 1'b0,
                                     cur_ff.ctrl.delay_sel, 1'b0, cur_ff.ctrl.mode};
                tcm_pkg::OFF_TRIGGER_POINT_MASK:
                    nxt_st.prdata[tcm_pkg::EVENT_POINTS-1:0] = cur_ff.trigger_point_mask;
                tcm_pkg::OFF_STATUS:
                begin
                    nxt_st.prdata[tcm_pkg::ST_HALTED_BIT] = cur_ff.st == tcm_pkg::ST_HALT;
                    nxt_st.prdata[tcm_pkg::ST_RUN_BIT] = cur_ff.st == tcm_pkg::ST_RUN;
                    nxt_st.prdata[tcm_pkg::ST_WRAP_BIT] = cur_ff.wrapped;
                    nxt_st.prdata[tcm_pkg::ST_WAIT_BIT] = cur_ff.st == tcm_pkg::ST_WAIT_EXT;
                    nxt_st.prdata[tcm_pkg::ST_FULL_BIT] = cur_ff.full;
                end
                tcm_pkg::OFF_WPTR: nxt_st.prdata[ADDR_W-1:0] = cur_ff.wptr;
                tcm_pkg::OFF_RD_ADDR: nxt_st.prdata[ADDR_W-1:0] = cur_ff.rd_addr;
                tcm_pkg::OFF_RD_DATA: nxt_st.prdata = 32'(mem_rdata);
                default: nxt_st.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            cur_ff <= '{st: tcm_pkg::ST_IDLE, ctrl: tcm_pkg::CTRL_RST,
                        trigger_point_mask: tcm_pkg::TRIGGER_POINT_MASK_RST, default: '0};
        end
        else if (ce_in)
        begin
            cur_ff <= nxt_st;
        end
    end

    // record = trigger mark above the observed bus data; 4M deep by default
    tcm_trace_mem #(.ADDR_W(ADDR_W), .DATA_W(DATA_W + 1)) u_mem (
        .core_clk_in(core_clk_in),
        .ce_in(ce_in),
        .we_in(mem_we && !rst_in),
        .waddr_in(mem_waddr),
        .wdata_in({first_hit, cyc_data_in}),
        .raddr_in(cur_ff.rd_addr),
        .rdata_out(mem_rdata)
    );

    assign pready_out = ce_in;
    assign pslverr_out = psel_in && penable_in && !mapped;
    assign prdata_out = cur_ff.prdata;
    assign halted_out = cur_ff.st == tcm_pkg::ST_HALT;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    wrap_overwrite_a: assert property (ce_in && mem_we && !is_rep && cur_ff.wptr == LAST &&
        !target_stop_in && !stop_now && cur_ff.ctrl.mode == tcm_pkg::MODE_FILL_STOP
        |=> cur_ff.wptr == {ADDR_W{1'b0}} && cur_ff.wrapped) else $error("no wrap to oldest");
    mode_legal_a: assert property (cur_ff.ctrl.mode <= tcm_pkg::MODE_REP_FULL)
        else $error("illegal mode held");
    full_halt_a: assert property (ce_in && mem_we && cur_ff.wptr == LAST &&
        cur_ff.st == tcm_pkg::ST_RUN && cur_ff.ctrl.mode == tcm_pkg::MODE_FILL_FULL
        |=> halted_out && cur_ff.full) else $error("fill until full overwrote");
    stop_halt_a: assert property (ce_in && cur_ff.st == tcm_pkg::ST_RUN && target_stop_in &&
        !(wr_acc && paddr_in[7:0] == tcm_pkg::OFF_CTRL) |=> halted_out ##1 halted_out || !ce_in)
        else $error("stop did not halt");
    delay_zero_a: assert property (ce_in && cur_ff.st == tcm_pkg::ST_RUN && cyc_valid_in &&
        first_hit && !cur_ff.trig_seen && cur_ff.ctrl.delay_sel == 3'h0 && !wr_acc &&
        cur_ff.ctrl.mode == tcm_pkg::MODE_AROUND_TRIGGER_POINT |=> halted_out)
        else $error("zero delay late");
    delay_range_a: assert property (delay_cnt <= CNT_W'(DEPTH) &&
        delay_cnt[ADDR_W-3:0] == '0) else $error("delay not a legal step");
    trigger_scope_a: assert property (first_hit |-> is_rep ||
        cur_ff.ctrl.mode == tcm_pkg::MODE_AROUND_TRIGGER_POINT)
        else $error("trigger in wrong mode");
    window_end_a: assert property (ce_in && cur_ff.in_post && cyc_valid_in &&
        cur_ff.post_cnt == POST_LAST && cur_ff.st == tcm_pkg::ST_RUN && !wr_acc
        |=> !cur_ff.in_post && cur_ff.wptr == $past(cur_ff.wptr) + WIN_SPAN)
        else $error("window length wrong");
    mark_once_a: assert property (ce_in && cyc_valid_in && trigger_point_hit && !wr_acc
        |=> !first_hit) else $error("consecutive hit marked");
    rep_nofilter_a: assert property (cur_ff.st == tcm_pkg::ST_RUN && is_rep &&
        cyc_valid_in |-> mem_we) else $error("filter applied in repeat mode");
endmodule

// *** rtl/tcm_trace_mem.sv ***
`timescale 1ns/10ps
module tcm_trace_mem #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 33
) (
    // clock
    input wire logic core_clk_in,
    input wire logic ce_in,
    // write side
    input wire logic we_in,
    input wire logic [ADDR_W-1:0] waddr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    // read side, one cycle latency
    input wire logic [ADDR_W-1:0] raddr_in,
    output logic [DATA_W-1:0] rdata_out
);
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
    } tcm_mem_state_s;

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    tcm_mem_state_s cur_ff;
    tcm_mem_state_s nxt_st;

    always_comb
    begin
        nxt_st = cur_ff;
        nxt_st.rdata = mem[raddr_in];
    end

    always_ff @(posedge core_clk_in)
    begin
        if (ce_in)
        begin
            cur_ff <= nxt_st;
            if (we_in)
            begin
                mem[waddr_in] <= wdata_in;
            end
        end
    end

    assign rdata_out = cur_ff.rdata;
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
    localparam int DEPTH = 2048;
    // arm with immediate start
    localparam logic [31:0] GO = 32'h8001_0000;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic target_stop = 1'b0;
    logic ext_trig = 1'b0;
    logic qual = 1'b1;
    logic step = 1'b0;
    tcm_pkg::tcm_apb_req_s req = '0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic halted_out;
    logic cyc_valid;
    logic [31:0] cyc_data;
    logic [15:0] event_hit;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [31:0] s0;
    logic [2:0] em;
    int gap;
    int miscompares = 0;
    int checked = 0;

    tcm_trace_ctrl #(.DEPTH(DEPTH), .DATA_W(31)) tcm_trace_ctrl_i (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .psel_in(req.psel), .penable_in(req.penable), .pwrite_in(req.pwrite),
        .paddr_in(req.paddr), .pwdata_in(req.pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .cyc_valid_in(cyc_valid), .cyc_data_in(cyc_data[30:0]),
        .target_stop_in(target_stop), .step_active_in(step), .event_hit_in(event_hit),
        .capture_qual_in(qual), .ext_trig_in(ext_trig), .halted_out(halted_out));

    tcm_bus_model tcm_bus_model_i (.core_clk_in(core_clk_in), .cyc_valid_out(cyc_valid),
        .cyc_data_out(cyc_data), .event_hit_out(event_hit));

    initial forever #25 core_clk_in = ~core_clk_in;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {24'h0, a}, pwdata: d};
        @(posedge core_clk_in);
        req.penable <= 1'b1;
        do
            @(posedge core_clk_in);
        while (pready_out !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge core_clk_in);
    endtask

    // expected value is {pslverr, prdata}
    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [32:0] m = 33'h1_FFFF_FFFF);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic mem(input int a, input logic mk, input logic [31:0] v);
        apb(1'b1, tcm_pkg::OFF_RD_ADDR, 32'(a));
        rd(tcm_pkg::OFF_RD_DATA, {1'b0, mk, v[30:0]});
    endtask

    task automatic stop_target();
        target_stop <= 1'b1;
        @(posedge core_clk_in);
        target_stop <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_in)
        if (req.psel && req.penable && pready_out === 1'b1 && !req.pwrite && exp_q.size() > 0)
        begin
            checked++;
            if ((({pslverr_out, prdata_out} ^ exp_q[0]) & msk_q[0]) !== 33'h0)
            begin
                miscompares++;
                $display("wrong value reg_%h expected %h seen %h", req.paddr[7:0], exp_q[0],
                         {pslverr_out, prdata_out});
            end
            if (req.paddr[7:0] == tcm_pkg::OFF_STATUS && msk_q[0][0] &&
                halted_out !== exp_q[0][0])
            begin
                miscompares++;
                $display("wrong value halted_out expected %b seen %b", exp_q[0][0], halted_out);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end

    // all scenarios take about 16000 cycles with the widest gaps; allow 40000, two and a half times that
    initial
    begin
        #(40000 * 50);
        miscompares++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(57798));
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        rd(tcm_pkg::OFF_CTRL, 33'h0);
        rd(tcm_pkg::OFF_TRIGGER_POINT_MASK, 33'h0);
        rd(tcm_pkg::OFF_STATUS, 33'h0);
        rd(8'h18, 33'h1_0000_0000);
        em = 3'h0;
        for (int m = 0; m < 8; m++)
        begin
            apb(1'b1, tcm_pkg::OFF_CTRL, 32'(m));
            if (m < 5)
                em = 3'(m);
            rd(tcm_pkg::OFF_CTRL, {30'h0, em}, 33'h1_0000_0007);
        end
        // external trigger start
        apb(1'b1, tcm_pkg::OFF_CTRL, 32'h8000_0000);
        rd(tcm_pkg::OFF_STATUS, 33'h8, 33'h8);
        tcm_bus_model_i.send(2, 0, 0, 0);
        ext_trig <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        tcm_bus_model_i.send(4, 0, 0, 1);
        rd(tcm_pkg::OFF_WPTR, 33'h4);
        stop_target();
        apb(1'b1, tcm_pkg::OFF_TRIGGER_POINT_MASK, 32'h1);
        // fill until full, hit present but ignored
        gap = $urandom_range(0, 2);
        apb(1'b1, tcm_pkg::OFF_CTRL, GO | 32'h1);
        s0 = tcm_bus_model_i.seq;
        tcm_bus_model_i.send(DEPTH + 3, 0, 1, gap);
        rd(tcm_pkg::OFF_STATUS, 33'h11, 33'h11);
        mem(0, 1'b0, s0);
        mem(DEPTH - 1, 1'b0, s0 + DEPTH - 1);
        // fill until stop wraps over the oldest
        apb(1'b1, tcm_pkg::OFF_CTRL, GO);
        s0 = tcm_bus_model_i.seq;
        tcm_bus_model_i.send(DEPTH + 5, 0, 0, $urandom_range(0, 2));
        rd(tcm_pkg::OFF_STATUS, 33'h4, 33'h5);
        stop_target();
        rd(tcm_pkg::OFF_STATUS, 33'h5, 33'h5);
        rd(tcm_pkg::OFF_WPTR, 33'h5);
        mem(0, 1'b0, s0 + DEPTH);
        mem(5, 1'b0, s0 + 5);
        // drop on qualifier, then step cycles without and with step recording
        apb(1'b1, tcm_pkg::OFF_CTRL, GO | 32'h200);
        tcm_bus_model_i.send(3, 0, 0, 0);
        qual <= 1'b0;
        step <= 1'b1;
        tcm_bus_model_i.send(2, 0, 0, 0);
        rd(tcm_pkg::OFF_WPTR, 33'h0);
        qual <= 1'b1;
        apb(1'b1, tcm_pkg::OFF_CTRL, GO | 32'h1100);
        tcm_bus_model_i.send(2, 0, 0, 0);
        step <= 1'b0;
        rd(tcm_pkg::OFF_WPTR, 33'h2);
        // around trigger, delay code 1 is a quarter of the depth
        apb(1'b1, tcm_pkg::OFF_CTRL, GO | 32'h12);
        tcm_bus_model_i.send(3 + DEPTH / 4, 3, 1, $urandom_range(0, 2));
        rd(tcm_pkg::OFF_STATUS, 33'h0, 33'h1);
        tcm_bus_model_i.send(1, 1, 0, 0);
        rd(tcm_pkg::OFF_STATUS, 33'h1, 33'h1);
        // zero delay halts at the hit cycle itself
        apb(1'b1, tcm_pkg::OFF_CTRL, GO | 32'h2);
        tcm_bus_model_i.send(4, 1, 1, 0);
        rd(tcm_pkg::OFF_WPTR, 33'h2);
        // repeat until stop, two hits in a row; the drop filter must not apply
        apb(1'b1, tcm_pkg::OFF_CTRL, GO | 32'h203);
        s0 = tcm_bus_model_i.seq;
        tcm_bus_model_i.send(267, 10, 2, $urandom_range(0, 2));
        rd(tcm_pkg::OFF_WPTR, 33'h200);
        mem(10, 1'b1, s0 + 10);
        mem(256, 1'b0, s0 + 11);
        mem(511, 1'b0, s0 + 266);
        rd(tcm_pkg::OFF_STATUS, 33'h0, 33'h1);
        stop_target();
        rd(tcm_pkg::OFF_STATUS, 33'h1, 33'h1);
        // repeat until full: four windows fill the memory
        apb(1'b1, tcm_pkg::OFF_CTRL, GO | 32'h4);
        repeat (3)
        begin
            tcm_bus_model_i.send(267, 10, 1, 0);
            @(posedge core_clk_in);
        end
        rd(tcm_pkg::OFF_STATUS, 33'h0, 33'h1);
        tcm_bus_model_i.send(267, 10, 1, 0);
        rd(tcm_pkg::OFF_STATUS, 33'h1, 33'h1);
        end_of_test();
    end
endmodule

// *** tb/tcm_bus_model.sv ***
`timescale 1ns/10ps
module tcm_bus_model (
    // clock
    input wire logic core_clk_in,
    // observed target bus
    output logic cyc_valid_out,
    output logic [31:0] cyc_data_out,
    output logic [15:0] event_hit_out
);
    logic [31:0] seq = 32'h0;

    initial
    begin
        cyc_valid_out = 1'b0;
        cyc_data_out = 32'h0;
        event_hit_out = 16'h0;
    end

    // idle data is inverted on each gap cycle and at the end of a send so a stale value is never mistaken for a record
    task automatic idle();
        cyc_valid_out <= 1'b0;
        cyc_data_out <= ~cyc_data_out;
        event_hit_out <= 16'h0;
    endtask

    // n bus cycles; event point 0 hits on cycles hit_at .. hit_at+hits-1
    task automatic send(input int n, input int hit_at, input int hits, input int gap);
        for (int i = 0; i < n; i++)
        begin
            cyc_valid_out <= 1'b1;
            cyc_data_out <= seq;
            event_hit_out <= (i >= hit_at && i < hit_at + hits) ? 16'h0001 : 16'h0000;
            seq = seq + 32'h1;
            @(posedge core_clk_in);
            for (int g = 0; g < gap; g++)
            begin
                idle();
                @(posedge core_clk_in);
            end
        end
        idle();
    endtask
endmodule
